// >>> pwt_cfg.svh
// Summary of operation
// RULE1: After reset the counter runs free and wraps instead of clearing on match.
// RULE2: The counter counts only while the start bit, mode bit 7, is one.
// RULE3: Rolling over from all ones to zero sets the overflow flag.
// RULE4: Overflow flag with its enable set raises the interrupt request.
// RULE5: In PWM mode register A sets the period, B, C and D the duties.
// RULE6: Three PWM outputs, pins B, C and D, each with its own duty register.
// RULE7: In PWM mode every general register acts as output compare automatically.
// RULE8: Level bit one: pin high at match A, low at its own match.
// RULE9: Level bit zero: pin low at match A, high at its own match.
// RULE10: A pin in PWM mode ignores both I/O control compare output settings.
// RULE11: Equal period and duty values leave that pin unchanged on match.
// RULE12: In PWM operation match A clears the counter to zero.
// RULE13: With level bits one each pin goes low at its own match.
// RULE14: Before any match each PWM pin shows the level of its level bit.
// RULE15: A pin runs PWM only while its PWM select bit is one.
// RULE16: Each match A to D sets its flag and requests interrupt when enabled.
`ifndef PWT_CFG_SVH
`define PWT_CFG_SVH
`define PWT_CNT_W      16
`define PWT_ADDR_W     6
`define PWT_OFF_MODE   6'h00
`define PWT_OFF_CTL    6'h04
`define PWT_OFF_IEN    6'h08
`define PWT_OFF_FLG    6'h0c
`define PWT_OFF_IOAB   6'h10
`define PWT_OFF_IOCD   6'h14
`define PWT_OFF_CNT    6'h18
`define PWT_OFF_GRA    6'h1c
`define PWT_OFF_GRB    6'h20
`define PWT_OFF_GRC    6'h24
`define PWT_OFF_GRD    6'h28
`define PWT_MODE_START 7
`define PWT_CTL_CLR    7
`define PWT_FLG_OVF    7
`define PWT_LVL_LO     1
`define PWT_LVL_HI     3
`define PWT_SEL_LO     0
`define PWT_SEL_HI     2
`define PWT_CODE_DN_LO 0
`define PWT_CODE_DN_HI 2
`define PWT_CODE_UP_LO 4
`define PWT_CODE_UP_HI 6
`define PWT_MATCH_LO   0
`define PWT_MATCH_HI   3
`define PWT_MODE_MASK  8'h87
`define PWT_CTL_MASK   8'h8f
`define PWT_FLG_MASK   8'h8f
`define PWT_IO_MASK    8'h77
`define PWT_IO_LOW     3'h1
`define PWT_IO_HIGH    3'h2
`define PWT_IO_TOG     3'h3
`define PWT_REG8_RST   8'h00
`define PWT_CNT_RST    16'h0000
`define PWT_GR_RST     16'hffff
`define PWT_RDATA_RST  32'h0000_0000
`endif

// >>> pwt_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwt_cfg.svh"
module pwt_counter #(
  parameter int WIDTH = `PWT_CNT_W
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic             run,
  input  wire logic             clear,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  output logic      [WIDTH-1:0] count,
  output logic                  wrap
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
  } pwt_cnt_state_type;

  pwt_cnt_state_type st;
  pwt_cnt_state_type next_st;

  if (WIDTH < 2) begin : g_check
    $error("pwt_counter: WIDTH must be at least 2");
  end

  always_comb begin
    next_st = st;
    wrap    = 1'b0;
    if (load) begin
      next_st.count = load_value;
    // RULE2 gated by start
    end else if (run) begin
      // RULE3 rollover detect
      wrap = &st.count;
      if (clear) begin
        next_st.count = '0;
      end else begin
        next_st.count = st.count + WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st.count <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign count = st.count;
endmodule // pwt_counter
`default_nettype wire

// >>> pwt_load_model.sv
`timescale 1ns/1ps
`default_nettype none
module pwt_load_model (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        pin_b,
  input  wire logic        pin_c,
  input  wire logic        pin_d,
  output logic      [15:0] hi_b,
  output logic      [15:0] hi_c,
  output logic      [15:0] hi_d
);
  // Each load integrates the cycles its pin is high
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hi_b <= 16'h0000;
      hi_c <= 16'h0000;
      hi_d <= 16'h0000;
    end else begin
      hi_b <= hi_b + 16'(pin_b);
      hi_c <= hi_c + 16'(pin_c);
      hi_d <= hi_d + 16'(pin_d);
    end
  end
endmodule // pwt_load_model
`default_nettype wire

// >>> pwt_pkg.sv
`default_nettype none
package pwt_pkg;
  typedef enum logic {
    pwt_bus_idle,
    pwt_bus_ack
  } pwt_bus_type;

  typedef struct packed {
    pwt_bus_type bus;
    logic        wait_req;
    logic [31:0] rdata;
    logic        irq;
    logic [7:0]  mode;
    logic [7:0]  ctl;
    logic [7:0]  ien;
    logic [7:0]  flags;
    logic [7:0]  io_ab;
    logic [7:0]  io_cd;
    logic [15:0] gr_a;
    logic [15:0] gr_b;
    logic [15:0] gr_c;
    logic [15:0] gr_d;
  } pwt_top_state_type;
endpackage
`default_nettype wire

// >>> pwt_pwm_chan.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwt_cfg.svh"
module pwt_pwm_chan (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       pwm_en,
  input  wire logic       level,
  input  wire logic       preset,
  input  wire logic       match_a,
  input  wire logic       match_own,
  input  wire logic       same_value,
  input  wire logic [2:0] io_code,
  output logic            pin
);
  typedef struct packed {
    logic pin;
  } pwt_chan_state_type;

  pwt_chan_state_type st;
  pwt_chan_state_type next_st;

  always_comb begin
    next_st = st;
    // RULE14 initial level
    if (preset) begin
      next_st.pin = level;
    // RULE15 PWM only when selected
    end else if (pwm_en) begin
      // RULE7 RULE10 compare fixed, codes ignored
      // RULE11 equal values hold
      if (!same_value) begin
        // RULE8 RULE9 period edge
        if (match_a) begin
          next_st.pin = level;
        end
        // RULE13 duty edge
        if (match_own) begin
          next_st.pin = ~level;
        end
      end
    end else if (match_own) begin
      case (io_code)
        `PWT_IO_LOW:  next_st.pin = 1'b0;
        `PWT_IO_HIGH: next_st.pin = 1'b1;
        `PWT_IO_TOG:  next_st.pin = ~st.pin;
        default:      next_st.pin = st.pin;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st.pin <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign pin = st.pin;
endmodule // pwt_pwm_chan
`default_nettype wire

// >>> pwt_timer.sv
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "pwt_cfg.svh"
module pwt_timer (
  input  wire logic                   clock,
  input  wire logic                   nrst,
  input  wire logic [`PWT_ADDR_W-1:0] avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic      [31:0]            avs_readdata,
  output logic                        avs_waitrequest,
  output logic                        irq,
  output logic                        pwm_pin_b,
  output logic                        pwm_pin_c,
  output logic                        pwm_pin_d
);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  function automatic logic [7:0] merge8(
    input logic [7:0]  old,
    input logic [31:0] wd,
    input logic [3:0]  be
  );
    merge8 = be[0] ? wd[7:0] : old;
  endfunction

  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [31:0] wd,
    input logic [3:0]  be
  );
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  function automatic logic is_match(
    input logic        run,
    input logic [15:0] cnt,
    input logic [15:0] cmp
  );
    is_match = run && (cnt == cmp);
  endfunction

  function automatic logic [31:0] pad8(
    input logic [7:0] v
  );
    pad8 = {24'h00_0000, v};
  endfunction

  function automatic logic [31:0] pad16(
    input logic [15:0] v
  );
    pad16 = {16'h0000, v};
  endfunction

  function automatic logic [7:0] reg8_write(
    input logic [7:0]  old,
    input logic [31:0] wd,
    input logic [3:0]  be,
    input logic [7:0]  mask
  );
    reg8_write = merge8(old, wd, be) & mask;
  endfunction

  function automatic logic lane_write(
    input logic                   go,
    input logic [`PWT_ADDR_W-1:0] addr,
    input logic [`PWT_ADDR_W-1:0] target,
    input logic                   lane
  );
    lane_write = go && (addr == target) && lane;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  pwt_pkg::pwt_top_state_type st;
  pwt_pkg::pwt_top_state_type next_st;

  logic [15:0] count;
  logic        wrap;
  logic        run;
  logic        pwm_any;
  logic        match_a;
  logic        match_b;
  logic        match_c;
  logic        match_d;
  logic        clear_a;
  logic        wr_go;
  logic        cnt_load;
  logic        ctl_write;
  logic [7:0]  flag_set;
  logic [7:0]  flag_clr;
  logic [31:0] read_word;
  logic [2:0]  pins;
  logic [2:0]  sel;
  logic [2:0]  lvl;
  logic [2:0]  duty_match;
  logic [2:0]  same_val;
  logic [2:0]  io_code [3];

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  // Counter and general registers must share one width
  if (`PWT_CNT_W != $bits(st.gr_a)) begin : g_width_check
    $error("pwt_timer: counter width differs from the general registers");
  end

  // Highest mapped offset must fit the address port
  if (`PWT_OFF_GRD >= (1 << `PWT_ADDR_W)) begin : g_addr_check
    $error("pwt_timer: address port too narrow for the register map");
  end

  // A 16-bit register must fit the read data word
  if ($bits(avs_readdata) < $bits(st.gr_a)) begin : g_rdata_check
    $error("pwt_timer: read data narrower than a general register");
  end

  // Start bit must survive the mode write mask
  if (((`PWT_MODE_MASK >> `PWT_MODE_START) & 8'h01) == 8'h00) begin : g_start_check
    $error("pwt_timer: start bit masked out of the mode register");
  end

  // Clear-on-match bit must survive the control write mask
  if (((`PWT_CTL_MASK >> `PWT_CTL_CLR) & 8'h01) == 8'h00) begin : g_clear_check
    $error("pwt_timer: clear bit masked out of the control register");
  end

  // Overflow flag must survive the flag mask
  if (((`PWT_FLG_MASK >> `PWT_FLG_OVF) & 8'h01) == 8'h00) begin : g_ovf_check
    $error("pwt_timer: overflow bit masked out of the flag register");
  end

  // One level bit per output channel
  if ((`PWT_LVL_HI - `PWT_LVL_LO + 1) != $bits(lvl)) begin : g_level_check
    $error("pwt_timer: level field does not cover the three channels");
  end

  // One select bit per output channel
  if ((`PWT_SEL_HI - `PWT_SEL_LO + 1) != $bits(sel)) begin : g_sel_check
    $error("pwt_timer: select field does not cover the three channels");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare logic

  // RULE2 start bit
  assign run     = st.mode[`PWT_MODE_START];
  assign pwm_any = |st.mode[`PWT_SEL_HI:`PWT_SEL_LO];
  // RULE5 period register
  assign match_a = is_match(run, count, st.gr_a);
  // RULE5 duty registers
  assign match_b = is_match(run, count, st.gr_b);
  assign match_c = is_match(run, count, st.gr_c);
  assign match_d = is_match(run, count, st.gr_d);

  // RULE12 RULE1 clear only in PWM or when chosen
  assign clear_a = match_a && (pwm_any || st.ctl[`PWT_CTL_CLR]);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  assign wr_go     = avs_write && (st.bus == pwt_pkg::pwt_bus_ack);
  assign cnt_load  = lane_write(wr_go, avs_address, `PWT_OFF_CNT, |avs_byteenable[1:0]);
  assign ctl_write = lane_write(wr_go, avs_address, `PWT_OFF_CTL, avs_byteenable[0]);

  always_comb begin
    case (avs_address)
      `PWT_OFF_MODE: read_word = pad8(st.mode);
      `PWT_OFF_CTL:  read_word = pad8(st.ctl);
      `PWT_OFF_IEN:  read_word = pad8(st.ien);
      `PWT_OFF_FLG:  read_word = pad8(st.flags);
      `PWT_OFF_IOAB: read_word = pad8(st.io_ab);
      `PWT_OFF_IOCD: read_word = pad8(st.io_cd);
      `PWT_OFF_CNT:  read_word = pad16(count);
      `PWT_OFF_GRA:  read_word = pad16(st.gr_a);
      `PWT_OFF_GRB:  read_word = pad16(st.gr_b);
      `PWT_OFF_GRC:  read_word = pad16(st.gr_c);
      `PWT_OFF_GRD:  read_word = pad16(st.gr_d);
      default:       read_word = `PWT_RDATA_RST;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag events

  always_comb begin
    flag_set = `PWT_REG8_RST;
    // RULE3 overflow flag
    flag_set[`PWT_FLG_OVF] = wrap;
    // RULE16 match flags
    flag_set[`PWT_MATCH_HI:`PWT_MATCH_LO] = {match_d, match_c, match_b, match_a};
    flag_clr = `PWT_REG8_RST;
    if (lane_write(wr_go, avs_address, `PWT_OFF_FLG, avs_byteenable[0])) begin
      flag_clr = avs_writedata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_st = st;
    case (st.bus)
      pwt_pkg::pwt_bus_idle: begin
        if (avs_read || avs_write) begin
          next_st.bus      = pwt_pkg::pwt_bus_ack;
          next_st.wait_req = 1'b0;
          next_st.rdata    = avs_read ? read_word : `PWT_RDATA_RST;
        end
      end
      pwt_pkg::pwt_bus_ack: begin
        next_st.bus      = pwt_pkg::pwt_bus_idle;
        next_st.wait_req = 1'b1;
      end
      default: begin
        next_st.bus      = pwt_pkg::pwt_bus_idle;
        next_st.wait_req = 1'b1;
      end
    endcase

    if (wr_go) begin
      case (avs_address)
        `PWT_OFF_MODE: begin
          next_st.mode = reg8_write(st.mode, avs_writedata, avs_byteenable, `PWT_MODE_MASK);
        end
        `PWT_OFF_CTL: begin
          next_st.ctl = reg8_write(st.ctl, avs_writedata, avs_byteenable, `PWT_CTL_MASK);
        end
        `PWT_OFF_IEN: begin
          next_st.ien = reg8_write(st.ien, avs_writedata, avs_byteenable, `PWT_FLG_MASK);
        end
        `PWT_OFF_IOAB: begin
          next_st.io_ab = reg8_write(st.io_ab, avs_writedata, avs_byteenable, `PWT_IO_MASK);
        end
        `PWT_OFF_IOCD: begin
          next_st.io_cd = reg8_write(st.io_cd, avs_writedata, avs_byteenable, `PWT_IO_MASK);
        end
        `PWT_OFF_GRA: begin
          next_st.gr_a = merge16(st.gr_a, avs_writedata, avs_byteenable);
        end
        `PWT_OFF_GRB: begin
          next_st.gr_b = merge16(st.gr_b, avs_writedata, avs_byteenable);
        end
        `PWT_OFF_GRC: begin
          next_st.gr_c = merge16(st.gr_c, avs_writedata, avs_byteenable);
        end
        `PWT_OFF_GRD: begin
          next_st.gr_d = merge16(st.gr_d, avs_writedata, avs_byteenable);
        end
        default: begin
          next_st.mode = st.mode;
        end
      endcase
    end

    // Set wins over a write-one clear in the same cycle
    next_st.flags = ((st.flags & ~flag_clr) | flag_set) & `PWT_FLG_MASK;
    // RULE4 RULE16 masked interrupt
    next_st.irq = |(next_st.flags & next_st.ien);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st.bus      <= pwt_pkg::pwt_bus_idle;
      st.wait_req <= 1'b1;
      st.rdata    <= `PWT_RDATA_RST;
      st.irq      <= 1'b0;
      st.mode     <= `PWT_REG8_RST;
      // RULE1 free-running after reset
      st.ctl      <= `PWT_REG8_RST;
      st.ien      <= `PWT_REG8_RST;
      st.flags    <= `PWT_REG8_RST;
      st.io_ab    <= `PWT_REG8_RST;
      st.io_cd    <= `PWT_REG8_RST;
      st.gr_a     <= `PWT_GR_RST;
      st.gr_b     <= `PWT_GR_RST;
      st.gr_c     <= `PWT_GR_RST;
      st.gr_d     <= `PWT_GR_RST;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter

  pwt_counter #(
    .WIDTH (`PWT_CNT_W)
  ) u_counter (
    .clock      (clock),
    .nrst       (nrst),
    .run        (run),
    .clear      (clear_a),
    .load       (cnt_load),
    .load_value (merge16(count, avs_writedata, avs_byteenable)),
    .count      (count),
    .wrap       (wrap)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output channels

  assign sel        = st.mode[`PWT_SEL_HI:`PWT_SEL_LO];
  // Level bits as they will stand after this edge, so a preset loads the new value
  assign lvl        = next_st.ctl[`PWT_LVL_HI:`PWT_LVL_LO];
  assign duty_match = {match_d, match_c, match_b};
  assign same_val   = {st.gr_d == st.gr_a, st.gr_c == st.gr_a, st.gr_b == st.gr_a};
  assign io_code[0] = st.io_ab[`PWT_CODE_UP_HI:`PWT_CODE_UP_LO];
  assign io_code[1] = st.io_cd[`PWT_CODE_DN_HI:`PWT_CODE_DN_LO];
  assign io_code[2] = st.io_cd[`PWT_CODE_UP_HI:`PWT_CODE_UP_LO];

  // RULE6 three channels
  for (genvar i = 0; i < 3; i++) begin : g_chan
    pwt_pwm_chan u_chan (
      .clock      (clock),
      .nrst       (nrst),
      .pwm_en     (sel[i]),
      .level      (lvl[i]),
      .preset     (ctl_write),
      .match_a    (match_a),
      .match_own  (duty_match[i]),
      .same_value (same_val[i]),
      .io_code    (io_code[i]),
      .pin        (pins[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign avs_readdata    = st.rdata;
  assign avs_waitrequest = st.wait_req;
  assign irq             = st.irq;
  assign pwm_pin_b       = pins[0];
  assign pwm_pin_c       = pins[1];
  assign pwm_pin_d       = pins[2];

endmodule // pwt_timer
`default_nettype wire

// >>> pwt_timer_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwt_cfg.svh"
module pwt_timer_assertions (
  input wire logic                   clock,
  input wire logic                   nrst,
  input wire logic [`PWT_ADDR_W-1:0] avs_address,
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic [31:0]            avs_writedata,
  input wire logic [3:0]             avs_byteenable,
  input wire logic [31:0]            avs_readdata,
  input wire logic                   avs_waitrequest,
  input wire logic                   irq,
  input wire logic                   pwm_pin_b,
  input wire logic                   pwm_pin_c,
  input wire logic                   pwm_pin_d
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  ////////////////////////
  sequence s_take;
    $rose(avs_read || avs_write);
  endsequence
  sequence s_answer;
    $fell(avs_waitrequest) ##1 avs_waitrequest;
  endsequence
  a_answer_time: assert property (s_take |=> s_answer)
    else $error("bus answer not a single cycle after request");
  a_answer_cause: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
    else $error("bus answer without request");
  a_upper_zero: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > `PWT_OFF_GRD
    |-> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property ($changed(avs_readdata) |-> $fell(avs_waitrequest))
    else $error("read data moved outside an answer");
  a_write_zero: assert property (avs_write && !avs_waitrequest |-> avs_readdata == 32'h0000_0000)
    else $error("write answer data not zero");
  a_irq_fall_write: assert property ($fell(irq) |-> $past(avs_write && !avs_waitrequest))
    else $error("interrupt dropped without a write");
  a_reset_quiet: assert property ($rose(nrst) |-> !irq && !pwm_pin_b && !pwm_pin_c
    && !pwm_pin_d && avs_waitrequest)
    else $error("outputs not idle after reset");
endmodule // pwt_timer_assertions
bind pwt_timer pwt_timer_assertions u_pwt_timer_assertions (.clock, .nrst, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
  .irq, .pwm_pin_b, .pwm_pin_c, .pwm_pin_d);
`default_nettype wire

// >>> test_sixteen_bit_pwm_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwt_cfg.svh"
module test_sixteen_bit_pwm_timer;
  logic                   clock, nrst, avs_read, avs_write, avs_waitrequest, irq;
  logic                   pwm_pin_b, pwm_pin_c, pwm_pin_d;
  logic [`PWT_ADDR_W-1:0] avs_address;
  logic [31:0]            avs_writedata, avs_readdata, q, v;
  logic [3:0]             avs_byteenable;
  logic [15:0]            hi_b, hi_c, hi_d, sb, sc, sd, ga, gb, gc;
  int                     n_fail, cmp_count, cyc, c0, c1;

  pwt_timer u_pwt_timer (.clock, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq, .pwm_pin_b, .pwm_pin_c, .pwm_pin_d);
  pwt_load_model u_pwt_load_model (.clock, .nrst, .pin_b(pwm_pin_b), .pin_c(pwm_pin_c),
    .pin_d(pwm_pin_d), .hi_b, .hi_c, .hi_d);
  ////////////////////////
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) cyc <= cyc + 1;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("Compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~we;
    avs_write <= we;
    do begin
      @(posedge clock);
      n++;
      if (n > 20) begin
        n_fail++;
        wrap_up();
      end
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    c0 = cyc;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask

  // High cycles of a pin over one period
  function automatic logic [31:0] high_cycles(logic lvl, logic [15:0] a, logic [15:0] d);
    if (d == a) return lvl ? 32'(a) + 1 : 0;
    return lvl ? 32'(d) + 1 : 32'(a - d);
  endfunction
  ////////////////////////
  initial begin
    {nrst, avs_read, avs_write, avs_address, avs_writedata} = '0;
    {avs_byteenable, cyc, n_fail, cmp_count} = '0;
    avs_byteenable = 4'hf;
    void'($urandom(32'h3723));
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    for (int a = 0; a <= 'h2c; a += 4) begin
      bus(1'b0, 6'(a), 0);
      chk(q, (a >= 'h1c && a <= 'h28) ? 32'h0000_ffff : 32'h0000_0000);
    end
    bus(1'b1, `PWT_OFF_GRB, 32'h0000_1234);
    avs_byteenable <= 4'h2;
    bus(1'b1, `PWT_OFF_GRB, 32'h0000_ab00);
    avs_byteenable <= 4'hf;
    bus(1'b0, `PWT_OFF_GRB, 0);
    chk(q, 32'h0000_ab34);
    bus(1'b1, `PWT_OFF_CNT, 32'h0000_0100);
    bus(1'b0, `PWT_OFF_CNT, 0);
    chk(q, 32'h0000_0100);
    bus(1'b1, `PWT_OFF_MODE, 32'h0000_0080);
    bus(1'b0, `PWT_OFF_CNT, 0);
    v = q;
    c1 = c0;
    bus(1'b0, `PWT_OFF_CNT, 0);
    chk(q - v, c0 - c1);
    bus(1'b1, `PWT_OFF_IEN, 32'h0000_0080);
    bus(1'b1, `PWT_OFF_CNT, 32'h0000_fff0);
    for (int n = 0; n < 100 && irq !== 1'b1; n++) @(posedge clock);
    if (irq !== 1'b1) begin
      n_fail++;
      wrap_up();
    end
    bus(1'b0, `PWT_OFF_CNT, 0);
    chk(32'(q < 32'h0000_0040), 1);
    bus(1'b1, `PWT_OFF_MODE, 0);
    bus(1'b0, `PWT_OFF_FLG, 0);
    chk(q, 32'h0000_008d);
    bus(1'b1, `PWT_OFF_IEN, 0);
    chk(irq, 0);
    bus(1'b1, `PWT_OFF_IEN, 32'h0000_0080);
    chk(irq, 1);
    bus(1'b1, `PWT_OFF_FLG, 32'h0000_00ff);
    chk(irq, 0);
    for (int k = 1; k < 4; k++) begin
      bus(1'b1, `PWT_OFF_CTL, 0);
      bus(1'b1, `PWT_OFF_IOAB, 32'(k << 4));
      bus(1'b1, `PWT_OFF_CNT, 0);
      bus(1'b1, `PWT_OFF_GRB, 32'h0000_0008);
      bus(1'b1, `PWT_OFF_MODE, 32'h0000_0080);
      repeat (20) @(posedge clock);
      bus(1'b1, `PWT_OFF_MODE, 0);
      chk(pwm_pin_b, k != 1);
    end
    // Free run passes match A; with the clear bit match A restarts the count
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, `PWT_OFF_CTL, 32'(k << `PWT_CTL_CLR));
      bus(1'b1, `PWT_OFF_GRA, 32'h0000_0004);
      bus(1'b1, `PWT_OFF_CNT, 0);
      bus(1'b1, `PWT_OFF_MODE, 32'h0000_0080);
      repeat (20) @(posedge clock);
      bus(1'b1, `PWT_OFF_MODE, 0);
      bus(1'b0, `PWT_OFF_CNT, 0);
      chk(32'(q > 32'h0000_0004), k == 0);
    end
    ga = 16'(24 + $urandom % 16);
    gb = ga - 16'h0001;
    gc = 16'($urandom % ga);
    // Code low on every pin must not reach a pin in PWM mode
    bus(1'b1, `PWT_OFF_IOAB, 32'h0000_0011);
    bus(1'b1, `PWT_OFF_IOCD, 32'h0000_0011);
    bus(1'b1, `PWT_OFF_GRA, 32'(ga));
    bus(1'b1, `PWT_OFF_GRB, 32'(gb));
    bus(1'b1, `PWT_OFF_GRC, 32'(gc));
    bus(1'b1, `PWT_OFF_GRD, 32'(ga));
    bus(1'b1, `PWT_OFF_IEN, 32'h0000_000f);
    bus(1'b1, `PWT_OFF_FLG, 32'h0000_00ff);
    bus(1'b1, `PWT_OFF_CNT, 0);
    bus(1'b1, `PWT_OFF_CTL, 32'h0000_000a);
    chk({pwm_pin_b, pwm_pin_c, pwm_pin_d}, 3'b101);
    bus(1'b1, `PWT_OFF_MODE, 32'h0000_0087);
    {sb, sc, sd} = {hi_b, hi_c, hi_d};
    repeat (4 * (ga + 1)) @(posedge clock);
    chk(hi_b - sb, 4 * high_cycles(1'b1, ga, gb));
    chk(hi_c - sc, 4 * high_cycles(1'b0, ga, gc));
    chk(hi_d - sd, 4 * high_cycles(1'b1, ga, ga));
    bus(1'b0, `PWT_OFF_CNT, 0);
    chk(32'(q[15:0] <= ga), 1);
    bus(1'b0, `PWT_OFF_FLG, 0);
    chk(q, 32'h0000_000f);
    chk(irq, 1);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    bus(1'b0, `PWT_OFF_MODE, 0);
    chk({q[7:0], irq, pwm_pin_b, pwm_pin_c, pwm_pin_d}, 0);
    wrap_up();
  end
endmodule // test_sixteen_bit_pwm_timer
`default_nettype wire
